// >>> vic_pkg.sv
// constants and helpers for the oscillator indirect port and modulator config
package vic_pkg;
  localparam logic [4:0]  OFS_IND     = 5'h05;
  localparam logic [4:0]  OFS_CFG     = 5'h06;
  localparam logic [15:0] IND_RESET   = 16'h0000;
  localparam logic [22:0] CFG_RESET   = 23'h200b4a;
  localparam int          IND_W       = 16;
  localparam int          CFG_W       = 23;
  localparam int          ID_LSB      = 0;
  localparam int          ADDR_LSB    = 3;
  localparam int          DATA_LSB    = 7;
  localparam int          SEED_LSB    = 0;
  localparam int          ORDER_LSB   = 2;
  localparam int          BYPASS_BIT  = 7;
  localparam int          RELOAD_BIT  = 8;
  localparam int          CLKSRC_BIT  = 9;
  localparam int          OVR_BIT     = 10;
  localparam int          CORE_BIT    = 11;
  localparam int          CHK_BIT     = 18;
  localparam int          LEN_LSB     = 19;
  localparam int          AUTO_BIT    = 21;
  localparam logic [23:0] SEED_LSB_V  = 24'h000001;
  localparam logic [23:0] SEED_C2     = 24'hb29d08;
  localparam logic [23:0] SEED_C3     = 24'h50f1cd;
  localparam logic [11:0] CHK_LEN0    = 12'h408;
  localparam logic [11:0] CHK_LEN1    = 12'h7ff;
  localparam logic [11:0] CHK_LEN2    = 12'hbff;
  localparam logic [11:0] CHK_LEN3    = 12'hfff;
  localparam logic [4:0]  FWD_LAST    = 5'h0f;

  function automatic logic [23:0] seed_fn(input logic [1:0] code);
    unique case (code)
      2'h0:    seed_fn = 24'h000000;
      2'h1:    seed_fn = SEED_LSB_V;
      2'h2:    seed_fn = SEED_C2;
      default: seed_fn = SEED_C3;
    endcase
  endfunction

  function automatic logic [11:0] chk_len(input logic [1:0] code);
    unique case (code)
      2'h0:    chk_len = CHK_LEN0;
      2'h1:    chk_len = CHK_LEN1;
      2'h2:    chk_len = CHK_LEN2;
      default: chk_len = CHK_LEN3;
    endcase
  endfunction
endpackage

// >>> vic_fwd_if.sv
// handoff between register bank and serial forwarder
interface vic_fwd_if;
  logic        start;
  logic [15:0] word;
  logic        busy;
  modport bank (output start, output word, input busy);
  modport fwd  (input start, input word, output busy);
endinterface

// >>> vic_fwd.sv
// serial forwarder to the oscillator subsystem
module vic_fwd (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  vic_fwd_if.fwd    f,
  output logic      sclk,
  output logic      sdata,
  output logic      load
);
  typedef enum logic [1:0] {F_IDLE, F_SHIFT, F_LOAD} vic_fst_e;
  vic_fst_e    st_reg;
  logic [15:0] sh_reg;
  logic [4:0]  cnt_reg;
  logic        ph_reg;
  logic        busy_reg;
  wire         last_bit = (cnt_reg == vic_pkg::FWD_LAST);

  assign f.busy = busy_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg   <= F_IDLE;
      sh_reg   <= 16'h0000;
      cnt_reg  <= 5'h00;
      ph_reg   <= 1'b0;
      busy_reg <= 1'b0;
      sclk     <= 1'b0;
      sdata    <= 1'b0;
      load     <= 1'b0;
    end else if (ce) begin
      load <= 1'b0;
      unique case (st_reg)
        F_IDLE: begin
          if (f.start) begin
            sh_reg   <= f.word;
            sdata    <= f.word[0];
            cnt_reg  <= 5'h00;
            ph_reg   <= 1'b0;
            busy_reg <= 1'b1;
            st_reg   <= F_SHIFT;
          end
        end
        F_SHIFT: begin
          ph_reg <= ~ph_reg;
          sclk   <= ~ph_reg;
          if (ph_reg) begin
            sh_reg  <= {1'b0, sh_reg[15:1]};
            sdata   <= sh_reg[1];
            cnt_reg <= cnt_reg + 5'h01;
            if (last_bit) st_reg <= F_LOAD;
          end
        end
        F_LOAD: begin
          load     <= 1'b1;
          busy_reg <= 1'b0;
          st_reg   <= F_IDLE;
        end
      endcase
    end
  end

  localparam logic [5:0] FWD_SPAN = 6'({vic_pkg::FWD_LAST, 1'b0} + 6'h02);
  logic [5:0] span_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) span_reg <= 6'h00;
    else if (ce) span_reg <= (st_reg == F_SHIFT) ? span_reg + 6'h01 : 6'h00;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_fwd_len;
    ce && (st_reg == F_LOAD) |-> span_reg == FWD_SPAN;
  endproperty
  a_fwd_len: assert property (p_fwd_len) else $error("forwarder length wrong");
endmodule // vic_fwd

// >>> vic_cfg.sv
// indirect oscillator port and modulator configuration register bank
// Function
// - indirect port: 3-bit id, 4-bit index, 9-bit data; all reset zero.
// - software writes to the port are forwarded serially without further command; writes made while a frame is pending go out as one frame with the last word.
// - port read returns the last word written to the port, sent or still pending; subsystem registers are not readable.
// - tuning controller rewrites only the data field; software keeps index zero.
// - seed code picks zero, lsb, or one of two 24-bit constants.
// - order field selects first, second order, mode B or mode A.
// - bypass ignores modulator output; modulator still clocked while core enabled.
// - clock source bit picks VCO clock; ignored if override or auto set.
// - core enable turns fractional core off or on.
// - core enable chooses integer or fraction word write to start tuning.
// - self check bit starts the self test; clear leaves it inactive.
// - check length code gives 1032, 2047, 3071 or 4095 cycles.
module vic_cfg (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [23:0] reg_wdata,
  output logic      [23:0] reg_rdata,
  input  wire logic        int_word_wr,
  input  wire logic        frac_word_wr,
  input  wire logic        cal_data_wr,
  input  wire logic [8:0]  cal_data,
  output logic             vsub_sclk,
  output logic             vsub_sdata,
  output logic             vsub_load,
  output logic             fwd_busy,
  output logic      [1:0]  mod_order,
  output logic             mod_out_used,
  output logic             mod_clock_run,
  output logic             mod_clk_vco_sel,
  output logic             mod_clk_auto,
  output logic             core_on,
  output logic             cal_start,
  output logic             seed_load,
  output logic      [23:0] seed_value,
  output logic             check_busy,
  output logic             check_done
);
  logic [15:0] ind_reg;
  logic [22:0] cfg_reg;
  logic        pend_reg;
  logic        start_reg;
  logic        chk_prev_reg;
  logic [11:0] chk_cnt_reg;

  vic_fwd_if fi ();

  wire        wr_ind   = reg_wr && (reg_addr == vic_pkg::OFS_IND);
  wire        wr_cfg   = reg_wr && (reg_addr == vic_pkg::OFS_CFG);
  wire        cal_upd  = cal_data_wr && !wr_ind;
  wire [15:0] ind_next = wr_ind  ? reg_wdata[15:0] :
                         cal_upd ? {cal_data, ind_reg[vic_pkg::DATA_LSB-1:0]} : ind_reg;
  wire [22:0] cfg_next = wr_cfg ? reg_wdata[22:0] : cfg_reg;
  wire        core_n   = cfg_next[vic_pkg::CORE_BIT];
  wire        auto_n   = cfg_next[vic_pkg::OVR_BIT] | cfg_next[vic_pkg::AUTO_BIT];
  wire        reload   = cfg_reg[vic_pkg::RELOAD_BIT];
  wire [1:0]  seed_cd  = cfg_reg[vic_pkg::SEED_LSB+1:vic_pkg::SEED_LSB];
  wire [1:0]  len_cd   = cfg_reg[vic_pkg::LEN_LSB+1:vic_pkg::LEN_LSB];
  wire        chk_on   = cfg_reg[vic_pkg::CHK_BIT];
  wire        chk_rise = chk_on && !chk_prev_reg;
  wire        do_start = pend_reg && !fi.busy && !start_reg;
  wire        ld_seed  = frac_word_wr && reload;
  wire        cal_go   = core_on ? frac_word_wr : int_word_wr;
  wire [23:0] rd_mux   = (reg_addr == vic_pkg::OFS_IND) ? {8'h00, ind_reg} :
                         (reg_addr == vic_pkg::OFS_CFG) ? {1'b0, cfg_reg} : 24'h000000;

  assign fi.start = start_reg;
  assign fi.word  = ind_reg;
  assign fwd_busy = fi.busy;

  vic_fwd u_fwd (
    .clk   (clk),
    .rstn  (rstn),
    .ce    (ce),
    .f     (fi),
    .sclk  (vsub_sclk),
    .sdata (vsub_sdata),
    .load  (vsub_load)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ind_reg <= vic_pkg::IND_RESET;
    else if (ce) ind_reg <= ind_next;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_reg  <= 1'b0;
      start_reg <= 1'b0;
    end else if (ce) begin
      pend_reg  <= wr_ind || cal_upd || (pend_reg && !start_reg);
      start_reg <= do_start;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg         <= vic_pkg::CFG_RESET;
      mod_order       <= vic_pkg::CFG_RESET[vic_pkg::ORDER_LSB+1:vic_pkg::ORDER_LSB];
      mod_out_used    <= 1'b1;
      mod_clock_run   <= 1'b1;
      mod_clk_vco_sel <= 1'b1;
      mod_clk_auto    <= 1'b1;
      core_on         <= 1'b1;
    end else if (ce) begin
      cfg_reg         <= cfg_next;
      mod_order       <= cfg_next[vic_pkg::ORDER_LSB+1:vic_pkg::ORDER_LSB];
      mod_out_used    <= !cfg_next[vic_pkg::BYPASS_BIT] && core_n;
      mod_clock_run   <= core_n;
      mod_clk_vco_sel <= cfg_next[vic_pkg::CLKSRC_BIT] || auto_n;
      mod_clk_auto    <= auto_n;
      core_on         <= core_n;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) reg_rdata <= 24'h000000;
    else if (ce && reg_rd) reg_rdata <= rd_mux;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seed_load  <= 1'b0;
      seed_value <= 24'h000000;
      cal_start  <= 1'b0;
    end else if (ce) begin
      seed_load <= ld_seed;
      cal_start <= cal_go;
      if (ld_seed) seed_value <= vic_pkg::seed_fn(seed_cd);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chk_prev_reg <= 1'b0;
      chk_cnt_reg  <= 12'h000;
      check_busy   <= 1'b0;
      check_done   <= 1'b0;
    end else if (ce) begin
      chk_prev_reg <= chk_on;
      check_done   <= check_busy && chk_on && (chk_cnt_reg == 12'h000);
      if (!chk_on) check_busy <= 1'b0;
      else if (chk_rise) begin
        check_busy  <= 1'b1;
        chk_cnt_reg <= vic_pkg::chk_len(len_cd) - 12'h001;
      end else if (check_busy) begin
        if (chk_cnt_reg == 12'h000) check_busy <= 1'b0;
        else chk_cnt_reg <= chk_cnt_reg - 12'h001;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_ind_wr;
    ce && wr_ind |=> ind_reg == $past(reg_wdata[15:0]);
  endproperty
  a_ind_wr: assert property (p_ind_wr) else $error("port write lost");
  property p_fwd_go;
    ce && wr_ind && !fi.busy && !pend_reg ##1 ce |=> start_reg;
  endproperty
  a_fwd_go: assert property (p_fwd_go) else $error("write not forwarded");
  property p_rd_ind;
    ce && reg_rd && reg_addr == vic_pkg::OFS_IND |=> reg_rdata == {8'h00, $past(ind_reg)};
  endproperty
  a_rd_ind: assert property (p_rd_ind) else $error("port readback wrong");
  property p_cal_keep;
    ce && cal_upd |=> ind_reg[6:0] == $past(ind_reg[6:0]) && ind_reg[15:7] == $past(cal_data);
  endproperty
  a_cal_keep: assert property (p_cal_keep) else $error("tuning touched id or index");
  property p_seed;
    ce && frac_word_wr && reload |=> seed_load && seed_value == vic_pkg::seed_fn($past(seed_cd));
  endproperty
  a_seed: assert property (p_seed) else $error("seed not loaded");
  property p_seed_hold;
    ce && !(frac_word_wr && reload) |=> !seed_load && $stable(seed_value);
  endproperty
  a_seed_hold: assert property (p_seed_hold) else $error("seed loaded early");
  property p_cfg_now;
    ce && wr_cfg |=> mod_order == $past(reg_wdata[3:2]) && core_on == $past(reg_wdata[11]);
  endproperty
  a_cfg_now: assert property (p_cfg_now) else $error("config not immediate");
  property p_bypass;
    cfg_reg[vic_pkg::BYPASS_BIT] |-> !mod_out_used && mod_clock_run == core_on;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass output used");
  property p_clk_ovr;
    mod_clk_auto |-> mod_clk_vco_sel;
  endproperty
  a_clk_ovr: assert property (p_clk_ovr) else $error("clock select not ignored");
  property p_cal_sel;
    ce && (core_on ? frac_word_wr : int_word_wr) |=> cal_start;
  endproperty
  a_cal_sel: assert property (p_cal_sel) else $error("tuning start wrong source");
  property p_chk_len;
    ce && check_busy && chk_on && chk_cnt_reg == 12'h000 |=> check_done && !check_busy;
  endproperty
  a_chk_len: assert property (p_chk_len) else $error("self check end wrong");
  property p_chk_off;
    ce && !chk_on |=> !check_busy;
  endproperty
  a_chk_off: assert property (p_chk_off) else $error("self check active when off");

  c_fwd: cover property (vsub_load);
  c_cal: cover property (cal_upd ##[1:40] vsub_load);
  c_seed: cover property (seed_load && seed_value == vic_pkg::SEED_C3);
  c_chk: cover property (check_done);
endmodule // vic_cfg

// >>> tb_vic_cfg.sv
// self-checking bench for the indirect port and modulator config bank
module tb_vic_cfg;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rstn = 0, ce = 1, reg_wr = 0, reg_rd = 0;
  logic [4:0]  reg_addr = 0;
  logic [23:0] reg_wdata = 0, reg_rdata, seed_value, c;
  logic        int_word_wr = 0, frac_word_wr = 0, cal_data_wr = 0;
  logic [8:0]  cal_data = 0;
  logic        vsub_sclk, vsub_sdata, vsub_load, fwd_busy, mod_out_used, mod_clock_run;
  logic        mod_clk_vco_sel, mod_clk_auto, core_on, cal_start, seed_load;
  logic        check_busy, check_done;
  logic [1:0]  mod_order;
  logic [31:0] rs = 32'hb6cd6e3b;
  logic [23:0] rq[$];
  logic [15:0] fq[$];
  logic [15:0] sh;
  logic        rd_pend = 0, sclk_d = 0;
  int          n_errors = 0, check_count = 0, n_loads = 0, nb = 0, n;
  logic [23:0] seeds[4] = '{24'h000000, 24'h000001, 24'hb29d08, 24'h50f1cd};
  logic [23:0] lens[4] = '{24'h000408, 24'h0007ff, 24'h000bff, 24'h000fff};

  vic_cfg u_vic_cfg (.clk, .rstn, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .int_word_wr, .frac_word_wr, .cal_data_wr, .cal_data, .vsub_sclk, .vsub_sdata,
    .vsub_load, .fwd_busy, .mod_order, .mod_out_used, .mod_clock_run, .mod_clk_vco_sel,
    .mod_clk_auto, .core_on, .cal_start, .seed_load, .seed_value, .check_busy, .check_done);

  always #4 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // read data and serial frame watcher
  always @(posedge clk) begin
    if (rd_pend) check("rdata", reg_rdata, rq.pop_front());
    rd_pend <= reg_rd && rstn;
    if (vsub_sclk && !sclk_d) begin
      sh = {vsub_sdata, sh[15:1]};
      nb++;
    end
    sclk_d <= vsub_sclk;
    if (vsub_load) begin
      check("frame", {nb[7:0], sh}, {8'h10, fq.pop_front()});
      nb = 0;
      n_loads++;
    end
  end

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    tick;
    reg_wr = 0;
    tick;
  endtask

  task automatic rd(input logic [4:0] a, input logic [23:0] e);
    rq.push_back(e);
    reg_rd = 1;
    reg_addr = a;
    tick;
    reg_rd = 0;
    tick;
  endtask

  task automatic wait_frame;
    int n0;
    n0 = n_loads;
    repeat (100) if (n_loads == n0) tick;
    if (n_loads == n0) begin
      n_errors++;
      report_and_stop;
    end
  endtask

  task automatic fw(input bit f, input logic [1:0] e);
    frac_word_wr = f;
    int_word_wr = !f;
    tick;
    frac_word_wr = 0;
    int_word_wr = 0;
    check("seed_cal", {seed_load, cal_start}, e);
    tick;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1 rstn = 1;
    rd(5'h05, 24'h000000);
    rd(5'h06, 24'h200b4a);
    rd(5'h1f, 24'h000000);
    for (int i = 0; i < 3; i++) begin
      rs = xs(rs);
      fq.push_back(rs[15:0]);
      wr(5'h05, rs[23:0]);
      if (i == 2) begin
        ce = 0;
        repeat (7) tick;
        ce = 1;
      end
      if (i == 1) begin
        rs = xs(rs);
        fq.push_back(rs[15:0]);
        tick;
        tick;
        check("busy", {23'h0, fwd_busy}, 24'h000001);
        wr(5'h05, rs[23:0]);
        wait_frame;
      end
      wait_frame;
      rd(5'h05, {8'h00, rs[15:0]});
      check("idle_fwd", {23'h0, fwd_busy}, 24'h000000);
    end
    fq.push_back(16'h0000);
    wr(5'h05, 24'h000000); // id and index zero
    wait_frame;
    rs = xs(rs);
    cal_data = rs[8:0];
    fq.push_back({rs[8:0], 7'h00});
    cal_data_wr = 1;
    tick;
    cal_data_wr = 0;
    wait_frame;
    rd(5'h05, {8'h00, rs[8:0], 7'h00});
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      c = rs[23:0] & 24'h3bffff;
      c[10] = i[0];
      c[21] = i[1];
      wr(5'h06, c);
      check("outs", {mod_order, mod_out_used, mod_clock_run, mod_clk_vco_sel, mod_clk_auto,
        core_on}, {c[3:2], !c[7] && c[11], c[11], c[9] | c[10] | c[21], c[10] | c[21],
        c[11]});
      rd(5'h06, c);
    end
    for (int i = 0; i < 4; i++) begin
      wr(5'h06, 24'h000b00 | i);
      fw(1, 2'b11);
      check("seed", seed_value, seeds[i]);
    end
    wr(5'h06, 24'h000a01);
    fw(1, 2'b01);
    check("seed_keep", seed_value, seeds[3]);
    wr(5'h06, 24'h000380); // integer mode, bypass
    fw(0, 2'b01);
    fw(1, 2'b10);
    for (int k = 0; k < 4; k++) begin
      wr(5'h06, 24'h070f4a | (k << 19)); // recommended fields
      n = 0;
      repeat (5000) if (!check_done) begin
        n += int'(check_busy);
        tick;
      end
      check("len", n[23:0], lens[k]);
      check("done", {23'h0, check_done}, 24'h000001);
      wr(5'h06, 24'h030f4a); // recommended fields
      check("idle", {23'h0, check_busy}, 24'h000000);
    end
    wr(5'h06, 24'h070f4a);
    repeat (50) tick;
    wr(5'h06, 24'h030f4a);
    check("abort", {22'h0, check_busy, check_done}, 24'h000000);
    tick;
    tick;
    report_and_stop;
  end
endmodule // tb_vic_cfg
